// file: oame_core.sv
// Four-phase execute unit for OR-with-file, literal load and move-file.
//
// Notes on behaviour
// - OR accumulator with file, update zero
// - Destination bit zero: accumulator; one: file
// - Literal loads accumulator, flags untouched
// - Move file to accumulator or itself
// - Move updates zero for both destinations
// - One word, four phases Q1..Q4
`timescale 1ns/1ps
`include "oame_defs.svh"

module oame_core
#(
	parameter int IW = 14
)
(
	input  wire logic               mclk,
	input  wire logic               sys_rst,
	input  wire logic [IW-1:0]      instr,
	input  wire logic [7:0]         file_rdata,
	output logic [6:0]              file_raddr,
	output oame_pkg::oame_fwr_t     file_wr,
	output logic [7:0]              acc,
	output logic                    zero_flag,
	output oame_pkg::oame_phase_t   phase,
	output logic                    instr_done
);
	import oame_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	oame_phase_t phase_r;
	oame_phase_t phase_nxt;
	oame_dec_t   dec;
	oame_dec_t   dec_r;
	oame_dec_t   dec_nxt;
	logic [7:0]  opnd_r;
	logic [7:0]  opnd_nxt;
	logic [7:0]  res_r;
	logic [7:0]  res_nxt;
	logic [7:0]  acc_r;
	logic [7:0]  acc_nxt;
	logic        zero_r;
	logic        zero_nxt;
	oame_fwr_t   fwr_r;
	oame_fwr_t   fwr_nxt;

	// ----------------------------------------------------------------
	// Decoder
	// ----------------------------------------------------------------
	oame_decode #(.IW(IW)) u_dec
	(
		.instr (instr),
		.dec   (dec)
	);

	// ----------------------------------------------------------------
	// Phase sequencer and datapath, next values
	// ----------------------------------------------------------------
	// The instruction word is captured in Q1, so the fetch side may change
	// it freely during the other three phases.
	always_comb
	begin
		phase_nxt = phase_r;
		dec_nxt   = dec_r;
		opnd_nxt  = opnd_r;
		res_nxt   = res_r;
		acc_nxt   = acc_r;
		zero_nxt  = zero_r;
		fwr_nxt   = '0;
		case (phase_r)
			OAME_Q1:
			begin
				dec_nxt   = dec;
				phase_nxt = OAME_Q2;
			end
			OAME_Q2:
			begin
				opnd_nxt  = (dec_r.kind == OAME_K_LIT) ? dec_r.lit : file_rdata;
				phase_nxt = OAME_Q3;
			end
			OAME_Q3:
			begin
				case (dec_r.kind)
					OAME_K_OR:  res_nxt = acc_r | opnd_r;
					OAME_K_MOV: res_nxt = opnd_r;
					OAME_K_LIT: res_nxt = opnd_r;
					default:    res_nxt = res_r;
				endcase
				phase_nxt = OAME_Q4;
			end
			OAME_Q4:
			begin
				case (dec_r.kind)
					OAME_K_OR, OAME_K_MOV:
					begin
						if (dec_r.dest == `OAME_DEST_ACC)
							acc_nxt = res_r;
						else
						begin
							fwr_nxt.we   = 1'b1;
							fwr_nxt.addr = dec_r.addr;
							fwr_nxt.data = res_r;
						end
						zero_nxt = (res_r == `OAME_BYTE_ZERO);
					end
					OAME_K_LIT: acc_nxt = res_r;
					default:    acc_nxt = acc_r;
				endcase
				phase_nxt = OAME_Q1;
			end
			default: phase_nxt = OAME_Q1;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			phase_r <= OAME_Q1;
			dec_r   <= '0;
			opnd_r  <= `OAME_BYTE_ZERO;
			res_r   <= `OAME_BYTE_ZERO;
			acc_r   <= `OAME_ACC_RST;
			zero_r  <= `OAME_ZERO_RST;
			fwr_r   <= '0;
		end
		else
		begin
			phase_r <= phase_nxt;
			dec_r   <= dec_nxt;
			opnd_r  <= opnd_nxt;
			res_r   <= res_nxt;
			acc_r   <= acc_nxt;
			zero_r  <= zero_nxt;
			fwr_r   <= fwr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// The read address is the latched field, valid through Q2 onward.
	assign file_raddr = dec_r.addr;
	assign file_wr    = fwr_r;
	assign acc        = acc_r;
	assign zero_flag  = zero_r;
	assign phase      = phase_r;
	assign instr_done = fwr_r.we | (phase_r == OAME_Q1 && !sys_rst);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_q4_done;
		phase_r == OAME_Q4 ##1 phase_r == OAME_Q1;
	endsequence

	AST_PHASE_CYCLE: assert property (@(posedge mclk) disable iff (sys_rst)
		phase_r == OAME_Q1 |=> phase_r == OAME_Q2 ##1 phase_r == OAME_Q3 ##1 s_q4_done)
		else $error("phase order broken");

	AST_OR_RESULT: assert property (@(posedge mclk) disable iff (sys_rst)
		(phase_r == OAME_Q4 && dec_r.kind == OAME_K_OR && dec_r.dest == 1'b0)
		|=> acc_r == ($past(acc_r) | $past(opnd_r)))
		else $error("or result wrong");

	AST_OR_TO_FILE: assert property (@(posedge mclk) disable iff (sys_rst)
		(phase_r == OAME_Q4 && dec_r.kind == OAME_K_OR && dec_r.dest == 1'b1)
		|=> fwr_r.we && fwr_r.addr == $past(dec_r.addr) && $stable(acc_r))
		else $error("or file write wrong");

	AST_LIT_LOAD: assert property (@(posedge mclk) disable iff (sys_rst)
		(phase_r == OAME_Q1 && dec.kind == OAME_K_LIT)
		|-> ##4 acc_r == $past(instr[`OAME_LIT_HI:`OAME_LIT_LO], 4) && $stable(zero_r))
		else $error("literal load wrong");

	AST_MOV_ACC: assert property (@(posedge mclk) disable iff (sys_rst)
		(phase_r == OAME_Q4 && dec_r.kind == OAME_K_MOV && dec_r.dest == 1'b0)
		|=> acc_r == $past(opnd_r) && !fwr_r.we)
		else $error("move to acc wrong");

	AST_MOV_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
		(phase_r == OAME_Q4 && dec_r.kind == OAME_K_MOV)
		|=> zero_r == ($past(opnd_r) == `OAME_BYTE_ZERO))
		else $error("move zero flag wrong");

	AST_ZERO_RULE: assert property (@(posedge mclk) disable iff (sys_rst)
		(phase_r == OAME_Q4 && dec_r.kind == OAME_K_OR)
		|=> zero_r == (($past(acc_r) | $past(opnd_r)) == `OAME_BYTE_ZERO))
		else $error("or zero flag wrong");

	AST_WRITE_ONLY_Q1: assert property (@(posedge mclk) disable iff (sys_rst)
		fwr_r.we |-> phase_r == OAME_Q1)
		else $error("write outside Q4 end");

	// A move onto itself must write the value it read and keep the accumulator.
	AST_MOV_TO_FILE: assert property (@(posedge mclk) disable iff (sys_rst)
		(phase_r == OAME_Q4 && dec_r.kind == OAME_K_MOV && dec_r.dest != `OAME_DEST_ACC)
		|=> fwr_r.we && fwr_r.data == $past(opnd_r) && $stable(acc_r))
		else $error("move to file wrong");

	// An unrecognised word runs its four phases but changes nothing.
	AST_IDLE_KEEPS: assert property (@(posedge mclk) disable iff (sys_rst)
		(phase_r == OAME_Q4 && dec_r.kind == OAME_K_NONE)
		|=> !fwr_r.we && $stable(acc_r) && $stable(zero_r))
		else $error("unknown word changed state");

	// The done flag marks only the decode phase of each cycle.
	AST_DONE_Q1: assert property (@(posedge mclk) disable iff (sys_rst)
		instr_done |-> phase_r == OAME_Q1)
		else $error("done outside Q1");

endmodule

// file: oame_decode.sv
// Instruction word decoder for the OR, literal-load and move-file block.
`timescale 1ns/1ps
`include "oame_defs.svh"

module oame_decode
#(
	parameter int IW = 14
)
(
	input  wire logic [IW-1:0]      instr,
	output oame_pkg::oame_dec_t     dec
);
	import oame_pkg::*;

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (IW != 14)
	begin : g_chk
		$error("oame_decode: instruction width must be 14");
	end

	// ----------------------------------------------------------------
	// Field split and opcode match
	// ----------------------------------------------------------------
	// The two low bits of the literal-load opcode are ignored on purpose.
	always_comb
	begin
		dec.dest = instr[`OAME_DEST_BIT];
		dec.addr = instr[`OAME_ADDR_HI:`OAME_ADDR_LO];
		dec.lit  = instr[`OAME_LIT_HI:`OAME_LIT_LO];
		if (instr[`OAME_OP_HI:`OAME_OP_LO] == `OAME_OPC_OR_FILE)
			dec.kind = OAME_K_OR;
		else if (instr[`OAME_OP_HI:`OAME_OP_LO] == `OAME_OPC_MOV_FILE)
			dec.kind = OAME_K_MOV;
		else if (instr[`OAME_OP_LIT_HI:`OAME_OP_LIT_LO] == `OAME_OPC_LIT_LOAD)
			dec.kind = OAME_K_LIT;
		else
			dec.kind = OAME_K_NONE;
	end

endmodule

// file: oame_defs.svh
// Constant definitions for the OR, literal-load and move-file execution block.
`ifndef OAME_DEFS_SVH
`define OAME_DEFS_SVH

// ----------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------
`define OAME_OP_HI        13
`define OAME_OP_LO        8
`define OAME_OP_LIT_HI    13
`define OAME_OP_LIT_LO    10
`define OAME_DEST_BIT     7
`define OAME_ADDR_HI      6
`define OAME_ADDR_LO      0
`define OAME_LIT_HI       7
`define OAME_LIT_LO       0

// ----------------------------------------------------------------
// Opcode patterns
// ----------------------------------------------------------------
`define OAME_OPC_OR_FILE  6'h04
`define OAME_OPC_MOV_FILE 6'h08
`define OAME_OPC_LIT_LOAD 4'hc

// ----------------------------------------------------------------
// Reset values and data constants
// ----------------------------------------------------------------
`define OAME_ACC_RST      8'h00
`define OAME_ZERO_RST     1'b0
`define OAME_BYTE_ZERO    8'h00
`define OAME_DEST_ACC     1'b0

`endif

// file: oame_pkg.sv
// Types shared by the OR, literal-load and move-file execution block.
package oame_pkg;

	// Four phases of one instruction cycle, Gray coded.
	typedef enum logic [1:0]
	{
		OAME_Q1 = 2'b00,
		OAME_Q2 = 2'b01,
		OAME_Q3 = 2'b11,
		OAME_Q4 = 2'b10
	} oame_phase_t;

	// Decoded instruction kind.
	typedef enum logic [1:0]
	{
		OAME_K_NONE = 2'b00,
		OAME_K_OR   = 2'b01,
		OAME_K_LIT  = 2'b10,
		OAME_K_MOV  = 2'b11
	} oame_kind_t;

	// Decoded instruction fields.
	typedef struct packed
	{
		oame_kind_t  kind;
		logic        dest;
		logic [6:0]  addr;
		logic [7:0]  lit;
	} oame_dec_t;

	// Write request towards the register file.
	typedef struct packed
	{
		logic        we;
		logic [6:0]  addr;
		logic [7:0]  data;
	} oame_fwr_t;

endpackage

// file: tb_top.sv
// Self-checking testbench for the OR, literal-load and move-file execute unit.
`timescale 1ns/1ps

module tb_top;
	import oame_pkg::*;

	logic        mclk;
	logic        sys_rst;
	logic [13:0] instr;
	logic [7:0]  file_rdata;
	logic [6:0]  file_raddr;
	oame_fwr_t   file_wr;
	logic [7:0]  acc;
	logic        zero_flag;
	oame_phase_t phase;
	logic        instr_done;
	int          miscompares;
	int          checks;

	oame_core #(.IW(14)) u_dut
	(
		.mclk       (mclk),
		.sys_rst    (sys_rst),
		.instr      (instr),
		.file_rdata (file_rdata),
		.file_raddr (file_raddr),
		.file_wr    (file_wr),
		.acc        (acc),
		.zero_flag  (zero_flag),
		.phase      (phase),
		.instr_done (instr_done)
	);

	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	// The clock toggles every half period of 2 ns.
	always #2 mclk = ~mclk;

	// One comparison; a mismatch is reported at once.
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Runs one instruction over four phases; read data is only valid in Q2,
	// elsewhere the inverse is shown so a late or early sample is caught.
	task automatic exec(input logic [13:0] ins, input logic [7:0] rd);
		instr = ins;
		file_rdata = ~rd;
		// Lets the combinational done flag settle right after a reset release.
		#1;
		chk("done_q1", 8'h01, {7'h00, instr_done});
		@(negedge mclk);
		chk("phase_q2", 8'h01, {6'h00, phase});
		chk("done_q2", 8'h00, {7'h00, instr_done});
		if (ins[13:12] == 2'b00)
			chk("raddr", {1'b0, ins[6:0]}, {1'b0, file_raddr});
		file_rdata = rd;
		@(negedge mclk);
		file_rdata = ~rd;
		chk("phase_q3", 8'h03, {6'h00, phase});
		@(negedge mclk);
		chk("phase_q4", 8'h02, {6'h00, phase});
		@(negedge mclk);
		chk("phase_q1", 8'h00, {6'h00, phase});
	endtask

	// Judges the outcome in the Q1 that follows the instruction.
	task automatic res(input logic [7:0] a, input logic z, input logic we, input logic [7:0] wd);
		chk("acc", a, acc);
		chk("zero", {7'h00, z}, {7'h00, zero_flag});
		chk("we", {7'h00, we}, {7'h00, file_wr.we});
		if (we)
			chk("wdata", wd, file_wr.data);
		if (we)
			chk("waddr", {1'b0, instr[6:0]}, {1'b0, file_wr.addr});
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Move to accumulator and onto itself, zero flag both ways.
	task automatic t_mov;
		exec(14'h082a, 8'h00);
		res(8'h00, 1'b1, 1'b0, 8'h00);
		exec(14'h08ff, 8'h80);
		res(8'h00, 1'b0, 1'b1, 8'h80);
		exec(14'h0801, 8'hc3);
		res(8'hc3, 1'b0, 1'b0, 8'h00);
		exec(14'h0880, 8'h00);
		res(8'hc3, 1'b1, 1'b1, 8'h00);
	endtask

	// Literal loads with don't-care pairs 11, 01 and 10 leave the flag alone.
	task automatic t_lit;
		exec(14'h335a, 8'h00);
		res(8'h5a, 1'b1, 1'b0, 8'h00);
		exec(14'h3100, 8'hff);
		res(8'h00, 1'b1, 1'b0, 8'h00);
		exec(14'h3291, 8'h00);
		res(8'h91, 1'b1, 1'b0, 8'h00);
	endtask

	// OR into accumulator, into the file, and to a zero result.
	task automatic t_or;
		exec(14'h0413, 8'h13);
		res(8'h93, 1'b0, 1'b0, 8'h00);
		exec(14'h04d5, 8'h40);
		res(8'h93, 1'b0, 1'b1, 8'hd3);
		exec(14'h3000, 8'h00);
		res(8'h00, 1'b0, 1'b0, 8'h00);
		exec(14'h0400, 8'h00);
		res(8'h00, 1'b1, 1'b0, 8'h00);
	endtask

	// Near-miss opcodes must leave every result untouched.
	task automatic t_unknown;
		exec(14'h0c00, 8'hff);
		res(8'h00, 1'b1, 1'b0, 8'h00);
		exec(14'h3455, 8'hff);
		res(8'h00, 1'b1, 1'b0, 8'h00);
	endtask

	// A reset in mid-instruction drops the pending write and restores reset state.
	task automatic t_reset;
		exec(14'h33a7, 8'hff);
		res(8'ha7, 1'b1, 1'b0, 8'h00);
		instr = 14'h04ff;
		file_rdata = 8'h01;
		repeat (2) @(negedge mclk);
		sys_rst = 1'b1;
		repeat (2) @(negedge mclk);
		chk("rst_acc", 8'h00, acc);
		chk("rst_zero", 8'h00, {7'h00, zero_flag});
		chk("rst_phase", 8'h00, {6'h00, phase});
		chk("rst_we", 8'h00, {7'h00, file_wr.we});
		chk("rst_done", 8'h00, {7'h00, instr_done});
		sys_rst = 1'b0;
		exec(14'h0400, 8'h00);
		res(8'h00, 1'b1, 1'b0, 8'h00);
	endtask

	// Prints the verdict and ends the run.
	task automatic conclude;
		if (miscompares == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	// Reset for three cycles, then back-to-back instructions from Q1.
	initial
	begin
		mclk = 1'b0;
		sys_rst = 1'b1;
		instr = 14'h0000;
		file_rdata = 8'h00;
		miscompares = 0;
		checks = 0;
		repeat (3) @(negedge mclk);
		sys_rst = 1'b0;
		t_mov;
		t_lit;
		t_or;
		t_unknown;
		t_reset;
		conclude;
	end

	// Far beyond the roughly 300 ns the scenarios need.
	initial
	begin
		#20000;
		miscompares++;
		conclude;
	end

endmodule
